// ---- bench/pio_pins.sv ----
// Pins and external memory facing the parallel port block.
// Assumes pull-ups on every bidirectional line.
`timescale 1ns/1ns
`default_nettype none
module pio_pins
  import pio_pkg::*;
(
  input  wire logic [NUM_PORTS-1:0][7:0] port_out, // Design pin values
  input  wire logic [NUM_PORTS-1:0][7:0] port_oe,  // Design pin enables
  input  wire pio_ext_bus_s              ext_bus,  // Memory bus request
  input  wire logic [7:0]                mem_data, // Memory read byte
  input  wire logic [NUM_PORTS-1:0][7:0] drv_val,  // Outside drive level
  input  wire logic [NUM_PORTS-1:0][7:0] drv_en,   // Outside drive enable
  output logic [NUM_PORTS-1:0][7:0]      port_in   // Resolved pin levels
);
  // ****************************************
  // Pin resolution
  // ****************************************
  logic [7:0] src;
  // Memory drives port zero only in a read data phase, else the outside drive wins where enabled and the pull-up elsewhere
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      src = (drv_en[p] & drv_val[p]) | ~drv_en[p];
      if (p == 0 && ext_bus.active && !ext_bus.addr_phase && !ext_bus.write) begin
        src = mem_data;
      end
      port_in[p] = (port_oe[p] & port_out[p]) | (~port_oe[p] & src);
    end
  end
endmodule
`default_nettype wire

// ---- bench/pio_ports_props.sv ----
// Checker for the parallel port block, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module pio_ports_props
  import pio_pkg::*;
(
  input wire logic                      clk_sys,        // Clock
  input wire logic                      rst_n,          // Reset
  input wire logic [7:0]                sfr_addr,       // Byte address
  input wire logic                      sfr_wr,         // Byte write
  input wire logic                      sfr_rd,         // Byte read
  input wire logic [7:0]                sfr_wdata,      // Write data
  input wire logic [7:0]                sfr_rdata,      // Read data
  input wire logic                      sfr_hit,        // Port hit
  input wire logic                      bit_wr,         // Bit write
  input wire pio_ext_bus_s              ext_bus,        // Memory bus
  input wire logic [7:0]                converter_ctrl, // Converter control
  input wire logic [CH_SEL_W-1:0]       analog_channel, // Channel
  input wire logic [NUM_PORTS-1:0][7:0] port_out,       // Pin values
  input wire logic [NUM_PORTS-1:0][7:0] port_oe,        // Pin enables
  input wire logic [7:0]                port_six_in     // Input pins
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Sync flops need two clean edges after reset before they carry pin levels
  sequence s_six_steady;
    $stable(port_six_in) [*2] ##1 $stable(port_six_in) && $past(rst_n, 2) && $past(rst_n);
  endsequence
  sequence s_w4;
    sfr_wr && sfr_addr == ADDR_PORT_FOUR && !bit_wr ##1 !sfr_wr && !bit_wr;
  endsequence
  a_six_read: assert property ((s_six_steady ##0 sfr_rd && sfr_addr == ADDR_PORT_SIX)
    |=> sfr_rdata == $past(port_six_in)) else $error("port six read differs");
  a_port_hit: assert property (sfr_rd && sfr_addr == ADDR_PORT_FIVE |=> sfr_hit)
    else $error("port read without hit");
  a_quasi_drive: assert property (port_oe[4] == ~port_out[4] && port_oe[5] == ~port_out[5])
    else $error("driver not fed by latch");
  a_byte_write: assert property (s_w4 |=> port_out[4] == $past(sfr_wdata, 2))
    else $error("port four write lost");
  a_chan_select: assert property ($past(rst_n) |-> analog_channel == $past(converter_ctrl[2:0]))
    else $error("channel select wrong");
  a_addr_low: assert property (ext_bus.active && ext_bus.addr_phase |=>
    port_out[0] == $past(ext_bus.addr[7:0]) && port_oe[0] == BYTE_ONES) else $error("low addr");
  a_addr_high: assert property (ext_bus.active && ext_bus.wide |=>
    port_out[2] == $past(ext_bus.addr[15:8]) && port_oe[2] == BYTE_ONES) else $error("high addr");
  a_read_float: assert property (ext_bus.active && !ext_bus.addr_phase && !ext_bus.write
    |=> port_oe[0] == BYTE_ZERO) else $error("port zero driven in read");
endmodule
`default_nettype wire

// ---- bench/pio_ports_tb.sv ----
// Self-checking bench for the parallel port block.
// Assumes pio_pins resolves the pins; the checker is bound at the foot.
`timescale 1ns/1ns
`default_nettype none
module pio_ports_tb;
  import pio_pkg::*;
  localparam logic [7:0] PADDR [6] = '{ADDR_PORT_ZERO, ADDR_PORT_ONE, ADDR_PORT_TWO,
    ADDR_PORT_THREE, ADDR_PORT_FOUR, ADDR_PORT_FIVE};
  logic                      clk_sys = 1'b0;
  logic                      rst_n = 1'b0;
  logic [7:0]                sfr_addr, sfr_wdata, sfr_rdata, bit_addr, ext_rdata, got, d, m;
  logic [7:0]                converter_ctrl, port_six_in, mem_data;
  logic                      sfr_wr, sfr_rd, sfr_hit, bit_wr, bit_rd, bit_wdata, bit_rdata;
  logic [CH_SEL_W-1:0]       analog_channel;
  pio_ext_bus_s              ext_bus;
  logic [NUM_PORTS-1:0][7:0] port_in, port_out, port_oe, drv_val, drv_en, latch, snap;
  int                        fail_count = 0, compares = 0, cycles = 0, seed = 91887, p;
  pio_ports DUT (.*);
  pio_pins u_pins (.*);
  always #10 clk_sys = ~clk_sys;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge clk_sys) sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk_sys) sfr_rd = 1'b0;
    got = sfr_rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Quasi pin: a latch 0 pulls low, a latch 1 lets the outside decide
  function automatic logic [7:0] pin_exp(input logic [7:0] l, v, e);
    return l & (~e | v);
  endfunction
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {sfr_addr, sfr_wdata, bit_addr, converter_ctrl, port_six_in, mem_data} = '0;
    {sfr_wr, sfr_rd, bit_wr, bit_rd, bit_wdata, ext_bus, drv_val, drv_en} = '0;
    latch = {BYTE_ONES, BYTE_ZERO, {4{BYTE_ONES}}};
    wt(5);
    rst_n = 1'b1;
    wt(3);
    for (int i = 0; i < 6; i++) begin
      rd(PADDR[i]);
      chk("reset pin", latch[i], got);
    end
    chk("oe four", BYTE_ONES, port_oe[4]);
    rd(8'h81);
    chk("unmapped hit", 8'h00, {got, sfr_hit} == 9'h000 ? 8'h00 : 8'h01);
    $display("test reset done");
    for (int k = 0; k < 40; k++) begin
      p = $unsigned($random(seed)) % 6;
      d = 8'($random(seed));
      drv_en[p] = 8'($random(seed));
      drv_val[p] = 8'($random(seed));
      if (k % 3 == 0) begin
        bit_addr = PADDR[p] | 8'(k % 8);
        bit_wdata = d[0];
        bit_wr = 1'b1;
        @(negedge clk_sys) bit_wr = 1'b0;
        latch[p][k % 8] = d[0];
      end else begin
        wr(PADDR[p], d);
        latch[p] = d;
      end
      wt(4);
      rd(PADDR[p]);
      chk("pin", pin_exp(latch[p], drv_val[p], drv_en[p]), got);
      chk("hit", 8'h01, {7'h00, sfr_hit});
      m = pin_exp(latch[p], drv_val[p], drv_en[p]);
      bit_addr = PADDR[p] | 8'(k % 8);
      bit_rd = 1'b1;
      @(negedge clk_sys) bit_rd = 1'b0;
      chk("bit pin", {7'h00, m[k % 8]}, {7'h00, bit_rdata});
    end
    $display("test ports done");
    for (int k = 0; k < 8; k++) begin
      port_six_in = 8'($random(seed));
      converter_ctrl = {5'($random(seed)), 3'(k)};
      snap = port_out;
      wr(ADDR_PORT_SIX, ~port_six_in);
      wt(3);
      rd(ADDR_PORT_SIX);
      m = ~(8'h01 << k);
      chk("six", port_six_in & m, got & m);
      chk("chan", 8'(k), {5'h00, analog_channel});
      chk("six write", 8'h01, {7'h00, snap === port_out});
    end
    port_six_in = BYTE_ONES;
    bit_addr = ADDR_PORT_SIX;
    bit_rd = 1'b1;
    @(negedge clk_sys) bit_rd = 1'b0;
    chk("six bit", 8'h00, {7'h00, bit_rdata});
    $display("test six done");
    drv_en = '0;
    mem_data = 8'($random(seed));
    wr(ADDR_PORT_TWO, 8'h5A);
    ext_bus = '{1'b1, 1'b1, 1'b0, 1'b1, 16'h1234, 8'h9A};
    wt(1);
    chk("addr low", 8'h34, port_out[0]);
    chk("p2 keep", 8'h5A, port_out[2]);
    ext_bus.wide = 1'b1;
    wt(1);
    chk("addr high", 8'h12, port_out[2]);
    ext_bus.addr_phase = 1'b0;
    wt(1);
    chk("wdata", 8'h9A, port_out[0]);
    ext_bus.write = 1'b0;
    wt(4);
    chk("ext rdata", mem_data, ext_rdata);
    ext_bus = '0;
    wt(3);
    rd(ADDR_PORT_TWO);
    chk("p2 latch", 8'h5A, got);
    $display("test bus done");
    test_done();
  end
endmodule
bind pio_ports pio_ports_props u_props (.*);
`default_nettype wire

// ---- verilog/pio_pkg.sv ----
// Shared constants and carriers for the parallel I/O port block.
// Assumes an 8-bit core that reaches ports through special function registers.
`default_nettype none
package pio_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int unsigned NUM_PORTS  = 6;
  localparam int unsigned PORT_W     = 8;
  localparam int unsigned CH_SEL_W   = 3;
  localparam int unsigned CH_SEL_LSB = 0;
  localparam int unsigned BIT_SEL_W  = 3;

  // ****************************************
  // Special function register addresses
  // ****************************************
  localparam logic [7:0] ADDR_PORT_ZERO  = 8'h80;
  localparam logic [7:0] ADDR_PORT_ONE   = 8'h90;
  localparam logic [7:0] ADDR_PORT_TWO   = 8'hA0;
  localparam logic [7:0] ADDR_PORT_THREE = 8'hB0;
  localparam logic [7:0] ADDR_PORT_FOUR  = 8'hE8;
  localparam logic [7:0] ADDR_PORT_FIVE  = 8'hF8;
  localparam logic [7:0] ADDR_PORT_SIX   = 8'hDB;
  localparam logic [7:0] BIT_BASE_MASK   = 8'hF8;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_PORT_ZERO  = 8'hFF;
  localparam logic [7:0] RST_PORT_ONE   = 8'hFF;
  localparam logic [7:0] RST_PORT_TWO   = 8'hFF;
  localparam logic [7:0] RST_PORT_THREE = 8'hFF;
  localparam logic [7:0] RST_PORT_FOUR  = 8'h00;
  localparam logic [7:0] RST_PORT_FIVE  = 8'hFF;
  localparam logic [7:0] BYTE_ONES      = 8'hFF;
  localparam logic [7:0] BYTE_ZERO      = 8'h00;

  // Port indices; NONE marks an address that is no port latch
  localparam logic [2:0] IDX_ZERO = 3'h0;
  localparam logic [2:0] IDX_TWO  = 3'h2;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // External memory bus request from the core's bus interface
  typedef struct packed {
    logic        active;      // External access in progress
    logic        addr_phase;  // Low address byte phase on port zero
    logic        wide;        // Access uses a 16-bit address
    logic        write;       // Data phase drives write data
    logic [15:0] addr;        // Access address
    logic [7:0]  wdata;       // Write data
  } pio_ext_bus_s;

endpackage

`default_nettype wire

// ---- verilog/pio_ports.sv ----
// Six bidirectional parallel ports, one input-only port and the pin sharing
// with the external memory bus. Assumes pins are resolved by the bench from
// out/oe, with a pull-up where no one drives.
`timescale 1ns/1ns
`default_nettype none

module pio_ports
  import pio_pkg::*;
(
  input  wire  logic                        clk_sys,          // System clock, 50 MHz
  input  wire  logic                        rst_n,            // Synchronous reset, active low
  input  wire  logic [7:0]                  sfr_addr,         // Byte register address
  input  wire  logic                        sfr_wr,           // Byte write strobe
  input  wire  logic                        sfr_rd,           // Byte read strobe
  input  wire  logic [7:0]                  sfr_wdata,        // Byte write data
  output logic [7:0]                        sfr_rdata,        // Byte read data, next cycle
  output logic                              sfr_hit,          // Last read hit a port register
  input  wire  logic [7:0]                  bit_addr,         // Bit address
  input  wire  logic                        bit_wr,           // Bit write strobe
  input  wire  logic                        bit_rd,           // Bit read strobe
  input  wire  logic                        bit_wdata,        // Bit write value
  output logic                              bit_rdata,        // Bit read value, next cycle
  input  wire  pio_ext_bus_s                ext_bus,          // External memory access
  output logic [7:0]                        ext_rdata,        // Data sampled from port zero
  input  wire  logic [7:0]                  converter_ctrl,   // Converter control register
  output logic [CH_SEL_W-1:0]               analog_channel,   // Selected analog channel
  input  wire  logic [NUM_PORTS-1:0][7:0]   port_in,          // Bidirectional pin levels
  output logic [NUM_PORTS-1:0][7:0]         port_out,         // Bidirectional pin values
  output logic [NUM_PORTS-1:0][7:0]         port_oe,          // Bidirectional pin enables
  input  wire  logic [7:0]                  port_six_in       // Input-only pin levels
);

  // ****************************************
  // Timing summary
  // ****************************************
  // Pin to register read: two synchroniser edges, then the read edge, so a
  // read sees the pins as they stood two edges before the read edge.
  // Register write to pin: the latch updates on the write edge and the
  // drivers one edge later, since driver outputs are registered.
  // Bus phase to pin: one edge, as the drivers sit behind the same flops.
  // Trade-off: registered drivers cost a cycle but keep pins glitch free
  // while the bus phases switch.

  // ****************************************
  // Address decode
  // ****************************************
  // Port index of a byte address; bit addresses pass their byte base
  function automatic logic [2:0] port_index(input logic [7:0] a);
    logic [2:0] idx;
    idx = IDX_NONE;
    unique case (a)
      ADDR_PORT_ZERO:  idx = 3'h0;
      ADDR_PORT_ONE:   idx = 3'h1;
      ADDR_PORT_TWO:   idx = 3'h2;
      ADDR_PORT_THREE: idx = 3'h3;
      ADDR_PORT_FOUR:  idx = 3'h4;
      ADDR_PORT_FIVE:  idx = 3'h5;
      default:         idx = IDX_NONE;
    endcase
    return idx;
  endfunction

  logic [2:0]           wr_idx;
  logic [2:0]           bit_idx;
  logic [BIT_SEL_W-1:0] bit_pos;

  always_comb begin
    wr_idx  = port_index(sfr_addr);
    bit_idx = port_index(bit_addr & BIT_BASE_MASK);
    bit_pos = bit_addr[BIT_SEL_W-1:0];
  end

  // One enable per latch keeps the latch process free of index arithmetic
  logic [NUM_PORTS-1:0] byte_we;
  logic [NUM_PORTS-1:0] bit_we;

  always_comb begin
    byte_we = '0;
    bit_we  = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      byte_we[p] = sfr_wr && (wr_idx == 3'(p));
      bit_we[p]  = bit_wr && (bit_idx == 3'(p));
    end
  end

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  // Two stages per line; only the second stage is ever read
  logic [NUM_PORTS-1:0][7:0] sync_a;
  logic [NUM_PORTS-1:0][7:0] pin_lvl;
  logic [7:0]                six_a;
  logic [7:0]                six_lvl;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_a  <= '1;
      pin_lvl <= '1;
      six_a   <= BYTE_ONES;
      six_lvl <= BYTE_ONES;
    end else begin
      sync_a  <= port_in;
      pin_lvl <= sync_a;
      six_a   <= port_six_in;
      six_lvl <= six_a;
    end
  end

  // ****************************************
  // Port latches
  // ****************************************
  logic [NUM_PORTS-1:0][7:0] latch;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      latch[0] <= RST_PORT_ZERO;
      latch[1] <= RST_PORT_ONE;
      latch[2] <= RST_PORT_TWO;
      latch[3] <= RST_PORT_THREE;
      latch[4] <= RST_PORT_FOUR;
      latch[5] <= RST_PORT_FIVE;
    end else begin
      // A write to the input-only address decodes to no latch
      for (int p = 0; p < NUM_PORTS; p++) begin
        // Byte write first so a bit write to the same port wins on its bit
        if (byte_we[p]) begin
          latch[p] <= sfr_wdata;
        end
        if (bit_we[p]) begin
          latch[p][bit_pos] <= bit_wdata;
        end
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Reading pins rather than latches lets a latch of one release the line
  // for an external driver; a bit held low outside reads low.
  logic       rd_hit;
  logic [7:0] rd_byte;
  logic       rd_bit;

  always_comb begin
    rd_hit  = 1'b0;
    rd_byte = BYTE_ZERO;
    if (sfr_addr == ADDR_PORT_SIX) begin
      rd_hit  = 1'b1;
      rd_byte = six_lvl;
    end else if (wr_idx != IDX_NONE) begin
      rd_hit  = 1'b1;
      rd_byte = pin_lvl[wr_idx];
    end
  end

  // Bit reads of the input-only port decode to no port and read zero
  always_comb begin
    rd_bit = 1'b0;
    if (bit_idx != IDX_NONE) begin
      rd_bit = pin_lvl[bit_idx][bit_pos];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sfr_rdata <= BYTE_ZERO;
      sfr_hit   <= 1'b0;
    end else if (sfr_rd) begin
      sfr_rdata <= rd_byte;
      sfr_hit   <= rd_hit;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bit_rdata <= 1'b0;
    end else if (bit_rd) begin
      bit_rdata <= rd_bit;
    end
  end

  // ****************************************
  // Analog channel select
  // ****************************************
  // Digital reads of port six stay live; analog bits read as noise to software
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      analog_channel <= '0;
    end else begin
      analog_channel <= converter_ctrl[CH_SEL_LSB +: CH_SEL_W];
    end
  end

  // ****************************************
  // Bus ownership
  // ****************************************
  // The bus interface owns port zero for the whole access and port two
  // only when the address is wide; the port zero phases never overlap.
  logic own_addr_low;
  logic own_wdata;
  logic own_rdata;
  logic own_addr_high;

  always_comb begin
    own_addr_low  = ext_bus.active && ext_bus.addr_phase;
    own_wdata     = ext_bus.active && !ext_bus.addr_phase && ext_bus.write;
    own_rdata     = ext_bus.active && !ext_bus.addr_phase && !ext_bus.write;
    own_addr_high = ext_bus.active && ext_bus.wide;
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  // Quasi-bidirectional: a latch zero pulls low, a one releases the line
  // so the same bit doubles as an input. The bus drives both levels.
  function automatic logic [7:0] quasi_oe(input logic [7:0] l);
    return ~l;
  endfunction

  logic [NUM_PORTS-1:0][7:0] next_out;
  logic [NUM_PORTS-1:0][7:0] next_oe;

  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_out[p] = latch[p];
      next_oe[p]  = quasi_oe(latch[p]);
    end
    if (own_addr_low) begin
      next_out[IDX_ZERO] = ext_bus.addr[7:0];
      next_oe[IDX_ZERO]  = BYTE_ONES;
    end else if (own_wdata) begin
      next_out[IDX_ZERO] = ext_bus.wdata;
      next_oe[IDX_ZERO]  = BYTE_ONES;
    end else if (own_rdata) begin
      // Released so the memory can drive the read byte
      next_out[IDX_ZERO] = BYTE_ONES;
      next_oe[IDX_ZERO]  = BYTE_ZERO;
    end
    if (own_addr_high) begin
      next_out[IDX_TWO] = ext_bus.addr[15:8];
      next_oe[IDX_TWO]  = BYTE_ONES;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      port_out <= '1;
      port_oe  <= '0;
    end else begin
      port_out <= next_out;
      port_oe  <= next_oe;
    end
  end

  // ****************************************
  // External read data
  // ****************************************
  // Sampled only in a read data phase; holds its value outside one
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_rdata <= BYTE_ZERO;
    end else if (own_rdata) begin
      ext_rdata <= pin_lvl[IDX_ZERO];
    end
  end

endmodule

`default_nettype wire
